// file: logic/backup_rail_cfg.svh
// Register offsets, field positions, reset values and codes of the backup rail
`ifndef BACKUP_RAIL_CFG_SVH
`define BACKUP_RAIL_CFG_SVH

// Register index 0x6B sits at byte address 4 * 0x6B on the bus
`define BRL_CTRL_INDEX 8'h6B
`define BRL_CTRL_ADDR 10'h1AC
`define BRL_STAT_ADDR 10'h1B0
`define BRL_ADDR_W 10
`define BRL_LEVEL_LSB 0
`define BRL_LEVEL_MSB 2
`define BRL_CTRL_RESET 8'h80
`define BRL_LEVEL_DEFAULT 3'h6
`define BRL_LEVEL_1V0 3'h0
`define BRL_LEVEL_1V8 3'h5
`define BRL_LEVEL_3V0 3'h6
`define BRL_LEVEL_RSVD 3'h7

`endif

// file: logic/backup_rail_pkg.sv
// Types shared by the backup rail mode logic
`default_nettype none
package backup_rail_pkg;
    typedef enum logic [3:0] {
        MODE_MAIN_LDO = 4'h1,
        MODE_CELL_LDO = 4'h2,
        MODE_CELL_SWITCH = 4'h4,
        MODE_FIRST_ATTACH = 4'h8
    } rail_mode_t;
endpackage
`default_nettype wire

// file: logic/rail_source_hyst.sv
// Comparator pair hysteresis tracker for the main input supply
`default_nettype none
module rail_source_hyst
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic high_code_i,
    input wire logic high_code_rise_threshold_i,
    input wire logic high_code_fall_threshold_i,
    input wire logic low_code_rise_threshold_i,
    input wire logic low_code_fall_threshold_i,
    output logic main_good_o
);
    logic good_q;
    logic good_d;
    logic rise;
    logic fall;

    // Rise and fall levels differ, so the state only flips past the far edge
    always_comb
    begin
        rise = high_code_i ? high_code_rise_threshold_i
                           : low_code_rise_threshold_i; // RULE11
        fall = high_code_i ? high_code_fall_threshold_i
                           : low_code_fall_threshold_i; // RULE11
        good_d = good_q;
        if (rise)
        begin
            good_d = 1'b1;
        end
        else if (!fall)
        begin
            good_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            good_q <= 1'b0;
        end
        else
        begin
            good_q <= good_d;
        end
    end

    assign main_good_o = good_q;
endmodule
`default_nettype wire

// file: logic/backup_rail_mode_select.sv
// Backup rail mode selector with its Wishbone control register
//
// Chosen here: the Wishbone slave port.
`include "backup_rail_cfg.svh"
`default_nettype none

// Summary of operation
// RULE1: Rail always fed by main input or backup cell; no setting turns it off.
// RULE2: Main input wins when above its threshold; else backup cell feeds rail.
// RULE3: Level field bits 2:0 encode 1.0 to 3.0 V; code 111 reserved.
// RULE4: Level resets to 110 unless fuse value programmed, which then wins.
// RULE5: First cell attach gives 1.0 V until main input later appears.
// RULE6: Main removal with cell: code 110 becomes switch, others stay regulator.
// RULE7: From the cell, codes 000 to 101 regulate at 1.8 V or below.
// RULE8: Code 110 from the cell closes a pass switch tracking the cell.
// RULE9: Level field lives in 8-bit register 0x6B; bits 7:3 unused.
// RULE10: Programmed level applies only while a valid supply is present.
// RULE11: Code 110 uses first threshold pair, other codes the second pair.
module backup_rail_mode_select
    import backup_rail_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic fuse_valid_i,
    input wire logic [2:0] fuse_level_i,
    input wire logic cell_present_i,
    input wire logic high_code_rise_threshold_i,
    input wire logic high_code_fall_threshold_i,
    input wire logic low_code_rise_threshold_i,
    input wire logic low_code_fall_threshold_i,
    output logic main_ldo_en_o,
    output logic cell_ldo_en_o,
    output logic pass_switch_en_o,
    output logic [2:0] always_on_rail_level_o,
    output logic [3:0] rail_mode_o
);
    // =====================================================================
    // Register bus
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic fuse_load_q;
    logic fuse_load_d;
    logic access;
    logic [2:0] backup_rail_level_sel;
    logic main_good;

    rail_mode_t mode_q;
    rail_mode_t mode_d;
    logic [2:0] out_level_q;
    logic [2:0] out_level_d;
    logic first_attach_q;
    logic first_attach_d;

    assign access = cyc_i && stb_i && !ack_q;
    assign backup_rail_level_sel = ctrl_q[`BRL_LEVEL_MSB:`BRL_LEVEL_LSB];

    function automatic logic [7:0] status_byte(input rail_mode_t m,
                                               input logic good,
                                               input logic first);
        status_byte = {2'h0, first, good, m};
    endfunction

    // Code 110 is the only code that uses the first comparator pair
    function automatic logic is_high_code(input logic [2:0] code);
        is_high_code = (code == `BRL_LEVEL_3V0);
    endfunction

    // Only the pass switch can deliver the 3.0 V code from the cell
    function automatic rail_mode_t cell_mode_for(input logic [2:0] code);
        if (is_high_code(code))
        begin
            cell_mode_for = MODE_CELL_SWITCH;
        end
        else
        begin
            cell_mode_for = MODE_CELL_LDO;
        end
    endfunction

    // Full address match, so an alias with upper bits set never writes
    function automatic logic reg_hit(input logic [31:0] adr,
                                     input logic [`BRL_ADDR_W-1:0] offs);
        reg_hit = (adr[`BRL_ADDR_W-1:0] == offs)
               && !(|adr[31:`BRL_ADDR_W]);
    endfunction

    always_comb
    begin
        ctrl_d = ctrl_q;
        ack_d = access;
        rdat_d = rdat_q;
        fuse_load_d = 1'b0;
        // Fuse value replaces the reset default one cycle after release
        if (fuse_load_q && fuse_valid_i)
        begin
            ctrl_d = {5'h00, fuse_level_i}; // RULE4
        end
        if (access)
        begin
            rdat_d = 32'h0000_0000;
            if (reg_hit(adr_i, `BRL_CTRL_ADDR))
            begin
                if (we_i && sel_i[0])
                begin
                    // Upper bits unused, never stored
                    ctrl_d = {5'h00, dat_i[2:0]}; // RULE9
                end
                rdat_d = {24'h00_0000, ctrl_q}; // RULE9
            end
            else if (reg_hit(adr_i, `BRL_STAT_ADDR))
            begin
                rdat_d = {24'h00_0000,
                          status_byte(mode_q, main_good, first_attach_q)};
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Bit 7 of the 0x80 default is an unused bit and is not kept
            ctrl_q <= {5'h00, `BRL_LEVEL_DEFAULT}; // RULE4 RULE9
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            fuse_load_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            fuse_load_q <= fuse_load_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    // =====================================================================
    // Supply source choice
    rail_source_hyst u_hyst
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .high_code_i(is_high_code(backup_rail_level_sel)), // RULE11
        .high_code_rise_threshold_i(high_code_rise_threshold_i),
        .high_code_fall_threshold_i(high_code_fall_threshold_i),
        .low_code_rise_threshold_i(low_code_rise_threshold_i),
        .low_code_fall_threshold_i(low_code_fall_threshold_i),
        .main_good_o(main_good)
    );

    // =====================================================================
    // Mode machine
    always_comb
    begin
        mode_d = mode_q;
        out_level_d = out_level_q;
        first_attach_d = first_attach_q;
        if (main_good)
        begin
            // Main input always takes precedence and ends first attach
            first_attach_d = 1'b0; // RULE5
            mode_d = MODE_MAIN_LDO; // RULE2
            // Reserved code keeps the last good level, rail stays up
            if (backup_rail_level_sel != `BRL_LEVEL_RSVD)
            begin
                out_level_d = backup_rail_level_sel; // RULE3 RULE10
            end
        end
        else if (first_attach_q)
        begin
            mode_d = MODE_FIRST_ATTACH; // RULE5
            out_level_d = `BRL_LEVEL_1V0; // RULE5
        end
        else
        begin
            // Level frozen without valid supply; register may still change
            case (mode_q)
                MODE_MAIN_LDO:
                begin
                    // Changeover keeps the level, only the path changes
                    mode_d = cell_mode_for(out_level_q); // RULE6 RULE7 RULE8
                end
                MODE_CELL_LDO,
                MODE_CELL_SWITCH:
                begin
                    // Level is frozen here, so the path holds steady
                    mode_d = cell_mode_for(out_level_q); // RULE7 RULE8
                end
                MODE_FIRST_ATTACH:
                begin
                    mode_d = cell_mode_for(out_level_q);
                end
                default:
                begin
                    // Illegal code: fall back to a path that fits the level
                    mode_d = cell_mode_for(out_level_q); // RULE1
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Reset models first attach of the cell: start at 1.0 V
            mode_q <= MODE_FIRST_ATTACH;
            out_level_q <= `BRL_LEVEL_1V0;
            first_attach_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            out_level_q <= out_level_d;
            first_attach_q <= first_attach_d;
        end
    end

    // Exactly one path always enabled, so the rail is never off
    assign main_ldo_en_o = (mode_q == MODE_MAIN_LDO); // RULE1
    assign pass_switch_en_o = (mode_q == MODE_CELL_SWITCH); // RULE8
    assign cell_ldo_en_o = (mode_q == MODE_CELL_LDO)
                        || (mode_q == MODE_FIRST_ATTACH); // RULE1 RULE7
    assign always_on_rail_level_o = out_level_q;
    assign rail_mode_o = mode_q;

    // cell_present_i is informational; cell fallback is assumed valid
    logic unused_cell;
    assign unused_cell = cell_present_i;
endmodule
`default_nettype wire

// file: dv/backup_rail_mode_select_monitor.sv
// Concurrent checks on the backup rail mode selector ports
`default_nettype none
module backup_rail_mode_select_monitor
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic high_code_rise_threshold_i,
    input wire logic high_code_fall_threshold_i,
    input wire logic low_code_rise_threshold_i,
    input wire logic low_code_fall_threshold_i,
    input wire logic main_ldo_en_o,
    input wire logic cell_ldo_en_o,
    input wire logic pass_switch_en_o,
    input wire logic [2:0] always_on_rail_level_o,
    input wire logic [3:0] rail_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [3:0] cmp = {high_code_rise_threshold_i,
        high_code_fall_threshold_i, low_code_rise_threshold_i,
        low_code_fall_threshold_i};
    // ==========
    // Rail and bus relations
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_up; (cmp == 4'hF) [*2]; endsequence
    sequence s_down; (cmp == 4'h0) [*2]; endsequence
    property p_src;
        $onehot({main_ldo_en_o, cell_ldo_en_o, pass_switch_en_o});
    endproperty
    a_src: assert property (p_src)
        else $error("rail source not one-hot");
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("request not acknowledged");
    property p_first;
        $fell(rst_i) |-> rail_mode_o == 4'h8 && always_on_rail_level_o == 3'h0;
    endproperty
    a_first: assert property (p_first)
        else $error("no first attach state after reset");
    property p_up; s_up |=> main_ldo_en_o; endproperty
    a_up: assert property (p_up)
        else $error("main input not selected");
    property p_down; s_down |=> !main_ldo_en_o; endproperty
    a_down: assert property (p_down)
        else $error("main input kept without supply");
    property p_cell;
        cell_ldo_en_o |-> always_on_rail_level_o <= 3'h5;
    endproperty
    a_cell: assert property (p_cell)
        else $error("cell regulator above top level");
    property p_sw;
        pass_switch_en_o |-> always_on_rail_level_o == 3'h6;
    endproperty
    a_sw: assert property (p_sw)
        else $error("pass switch on other code");
    // Cell mode picked at changeover must follow the applied code
    property p_chg;
        $fell(main_ldo_en_o) |->
            pass_switch_en_o == (always_on_rail_level_o == 3'h6);
    endproperty
    a_chg: assert property (p_chg)
        else $error("wrong cell mode at changeover");
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking testbench of the backup rail mode selector
`include "backup_rail_cfg.svh"
`default_nettype none
`define CHK(g, e) begin @(negedge clk_i); n_tests++; \
    if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench
    import backup_rail_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic fuse_valid_i = 0, cell_present_i = 1;
    logic high_code_rise_threshold_i = 0, high_code_fall_threshold_i = 0;
    logic low_code_rise_threshold_i = 0, low_code_fall_threshold_i = 0;
    logic main_ldo_en_o, cell_ldo_en_o, pass_switch_en_o;
    logic [3:0] sel_i = 0, rail_mode_o, s;
    logic [31:0] adr_i = 0, dat_i = 0, dat_o, rd;
    logic [2:0] fuse_level_i = 0, always_on_rail_level_o, c, ctl, lv;
    int err_count = 0, n_tests = 0;
    backup_rail_mode_select dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .sel_i, .adr_i, .dat_i, .dat_o, .ack_o, .fuse_valid_i, .fuse_level_i,
        .cell_present_i, .high_code_rise_threshold_i,
        .high_code_fall_threshold_i, .low_code_rise_threshold_i,
        .low_code_fall_threshold_i, .main_ldo_en_o, .cell_ldo_en_o,
        .pass_switch_en_o, .always_on_rail_level_o, .rail_mode_o);
    always #4 clk_i = ~clk_i;
    // ==========
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [31:0] a, d,
        input logic [3:0] m);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= m;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    // Pattern is {high rise, high fall, low rise, low fall}
    task automatic supply(input logic [3:0] v);
        @(posedge clk_i);
        {high_code_rise_threshold_i, high_code_fall_threshold_i,
            low_code_rise_threshold_i, low_code_fall_threshold_i} <= v;
        tick(3);
    endtask
    function automatic logic [3:0] cell_mode(input logic [2:0] k);
        return (k == `BRL_LEVEL_3V0) ? MODE_CELL_SWITCH : MODE_CELL_LDO;
    endfunction
    // Only the pair of the code drops, so a design using the other holds
    function automatic logic [3:0] loss(input logic [2:0] k);
        return (k == `BRL_LEVEL_3V0) ? 4'h3 : 4'hC;
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_count++;
        print_verdict();
    end
    // ==========
    // Tests
    initial
    begin
        void'($urandom(32'hDF59));
        tick(2);
        rst_i <= 0;
        tick(1);
        `CHK(rail_mode_o, MODE_FIRST_ATTACH)
        `CHK(always_on_rail_level_o, `BRL_LEVEL_1V0)
        wb(0, `BRL_CTRL_ADDR, 0, 4'hF);
        `CHK(rd, {29'h0, `BRL_LEVEL_DEFAULT})
        supply(4'hF);
        `CHK(rail_mode_o, MODE_MAIN_LDO)
        `CHK(always_on_rail_level_o, `BRL_LEVEL_DEFAULT)
        wb(0, `BRL_STAT_ADDR, 0, 4'hF);
        `CHK(rd[4:0], 5'h11)
        // Upper address bits set: must not alias onto the control register
        wb(1, 32'h0001_01AC, 32'hFF, 4'hF);
        wb(0, 32'h100, 0, 4'hF);
        `CHK(rd, 32'h0)
        wb(0, `BRL_CTRL_ADDR, 0, 4'hF);
        `CHK(rd, {29'h0, `BRL_LEVEL_DEFAULT})
        $display("Test attach_and_main done");
        ctl = `BRL_LEVEL_DEFAULT;
        lv = ctl;
        for (int i = 0; i < 24; i++)
        begin
            c = (i < 8) ? 3'(i) : 3'($urandom_range(7, 0));
            s = (i < 8) ? 4'h1 : 4'($urandom_range(15, 0));
            wb(1, `BRL_CTRL_ADDR, $urandom & 32'hFFFFFFF8 | c, s);
            if (s[0])
                ctl = c;
            if (ctl != `BRL_LEVEL_RSVD)
                lv = ctl;
            wb(0, `BRL_CTRL_ADDR, 0, 4'hF);
            `CHK(rd, {29'h0, ctl})
            `CHK(always_on_rail_level_o, lv)
            if (ctl != `BRL_LEVEL_RSVD)
            begin
                supply(i[0] ? 4'h0 : loss(ctl));
                `CHK(rail_mode_o, cell_mode(ctl))
                `CHK(always_on_rail_level_o, lv)
                supply(4'hF);
            end
        end
        $display("Test level_codes done");
        @(posedge clk_i);
        rst_i <= 1;
        fuse_valid_i <= 1;
        fuse_level_i <= 3'($urandom_range(5, 0));
        supply(4'h0);
        rst_i <= 0;
        tick(1);
        `CHK(rail_mode_o, MODE_FIRST_ATTACH)
        wb(0, `BRL_CTRL_ADDR, 0, 4'hF);
        `CHK(rd, {29'h0, fuse_level_i})
        supply(4'hF);
        `CHK(always_on_rail_level_o, fuse_level_i)
        $display("Test fuse_default done");
        print_verdict();
    end
endmodule
bind backup_rail_mode_select backup_rail_mode_select_monitor mon_u (.clk_i,
    .rst_i, .cyc_i, .stb_i, .ack_o, .high_code_rise_threshold_i,
    .high_code_fall_threshold_i, .low_code_rise_threshold_i,
    .low_code_fall_threshold_i, .main_ldo_en_o, .cell_ldo_en_o,
    .pass_switch_en_o, .always_on_rail_level_o, .rail_mode_o);
`default_nettype wire
